// ### rtl/srap_top.sv
// serial register access port: event fifo, link front end and register core
`timescale 1ns/1ps

module srap_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             i_wr_clk,
    input  wire logic             i_wr_rst,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_rd_clk,
    input  wire logic             i_rd_srst,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    // depth must be a power of two for the gray pointers
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] sync1;
        logic [AW:0] sync2;
    } srap_ptr_type;

    srap_ptr_type     wr_r;
    srap_ptr_type     wr_nxt;
    srap_ptr_type     rd_r;
    srap_ptr_type     rd_nxt;
    logic [WIDTH-1:0] mem [DEPTH];

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    // full view is stale by two write edges, which only errs toward full
    assign o_wr_ready = wr_r.gray != {~wr_r.sync2[AW:AW-1], wr_r.sync2[AW-2:0]};
    assign o_rd_valid = rd_r.gray != rd_r.sync2;
    // read data comes straight from the array, valid together with o_rd_valid
    assign o_rd_data  = mem[rd_r.bin[AW-1:0]];

    always_comb begin
        wr_nxt       = wr_r;
        wr_nxt.sync1 = rd_r.gray;
        wr_nxt.sync2 = wr_r.sync1;
        if (i_wr_valid && o_wr_ready) begin
            wr_nxt.bin  = wr_r.bin + {{AW{1'b0}}, 1'b1};
            wr_nxt.gray = to_gray(wr_nxt.bin);
        end
    end

    always_comb begin
        rd_nxt       = rd_r;
        rd_nxt.sync1 = wr_r.gray;
        rd_nxt.sync2 = rd_r.sync1;
        if (o_rd_valid && i_rd_ready) begin
            rd_nxt.bin  = rd_r.bin + {{AW{1'b0}}, 1'b1};
            rd_nxt.gray = to_gray(rd_nxt.bin);
        end
    end

    always_ff @(posedge i_wr_clk) begin
        if (i_wr_valid && o_wr_ready) begin
            mem[wr_r.bin[AW-1:0]] <= i_wr_data;
        end
    end

    // cleared asynchronously by the core's link reset, so the write side is
    // cleared even while the serial clock stands still between frames
    always_ff @(posedge i_wr_clk or posedge i_wr_rst) begin
        if (i_wr_rst) begin
            wr_r <= '0;
        end else begin
            wr_r <= wr_nxt;
        end
    end

    // the read side clears with the core reset, which shares its clock
    always_ff @(posedge i_rd_clk) begin
        if (i_rd_srst) begin
            rd_r <= '0;
        end else begin
            rd_r <= rd_nxt;
        end
    end

endmodule : srap_fifo

module srap_link
    import srap_pkg::*;
(
    input  wire logic       i_sclk,
    input  wire logic       i_port_select_n,
    input  wire logic       i_link_rst,
    input  wire logic       i_shift_in,
    input  wire logic [7:0] i_rd_byte,
    input  wire logic       i_ev_ready,
    output logic            o_ev_valid,
    output srap_event_type  o_ev,
    output logic            o_lost,
    output logic            o_shift_out,
    output logic            o_shift_out_oe_n
);
    srap_link_type link_r;
    srap_link_type link_nxt;
    srap_out_type  out_r;
    srap_out_type  out_nxt;
    logic          frame_rst;
    logic          lost_r;

    // select high holds the frame logic in reset, so a partial frame is dropped
    assign frame_rst = i_port_select_n | i_link_rst;

    always_comb begin
        link_nxt   = link_r;
        o_ev_valid = 1'b0;
        o_ev       = '{
            kind:    EV_ADDR,
            payload: '0
        };
        link_nxt.sh = {link_r.sh[ADDR_W-2:0], i_shift_in};
        // past the first frame the count loops over the data byte alone, so
        // each further group of eight edges carries one more byte
        if (link_r.cnt == CNT_FRAME) begin
            link_nxt.cnt = CNT_STREAM;
        end else begin
            link_nxt.cnt = link_r.cnt + 5'h01;
        end
        if (link_r.cnt == CNT_RW_BIT) begin
            link_nxt.rd = i_shift_in;
        end
        if (link_r.cnt == CNT_ADDR_END) begin
            o_ev_valid   = 1'b1;
            o_ev.payload = link_nxt.sh;
        end
        // a trailing byte cut short never reaches this count and is dropped
        if (link_r.cnt == CNT_DATA_END) begin
            o_ev_valid   = 1'b1;
            o_ev.kind    = link_r.rd ? EV_RDONE : EV_WDATA;
            o_ev.payload = {7'h00, link_nxt.sh[7:0]};
        end
    end

    // no counter runs between edges: any slow clock works
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            link_r <= LINK_RST;
        end else begin
            link_r <= link_nxt;
        end
    end

    // sticky: a dropped event cannot be replayed, so only a core reset clears it
    always_ff @(posedge i_sclk or posedge i_link_rst) begin
        if (i_link_rst) begin
            lost_r <= 1'b0;
        end else if (o_ev_valid && !i_ev_ready) begin
            lost_r <= 1'b1;
        end
    end

    // read byte is held steady by the core; it settles in about four core
    // clocks, well inside the half link period before the first data edge
    always_comb begin
        out_nxt      = out_r;
        // taken from the registered count, so the pin turns on at a falling edge
        out_nxt.oe_n = ~(link_r.rd && (link_r.cnt >= CNT_DATA_BEG));
        // a new byte loads after the address and at every byte boundary
        if (link_r.cnt == CNT_DATA_BEG ||
            link_r.cnt == CNT_FRAME) begin
            out_nxt.bit_o = i_rd_byte[7];
            out_nxt.pend  = i_rd_byte[6:0];
        end else begin
            out_nxt.bit_o = out_r.pend[6];
            out_nxt.pend  = {out_r.pend[5:0], 1'b0};
        end
    end

    // launching on the falling edge gives the host half a period of setup
    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            out_r <= OUT_RST;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign o_lost           = lost_r;
    assign o_shift_out      = out_r.bit_o;
    assign o_shift_out_oe_n = out_r.oe_n;

endmodule : srap_link

module srap_top
    import srap_pkg::*;
#(
    parameter logic [7:0]  PART_CATEGORY = 8'h5a,   // arbitrary value
    parameter logic [7:0]  PART_IDENT    = 8'h21,   // arbitrary value
    parameter logic [15:0] MAKER_IDENT   = 16'h1234, // arbitrary value
    parameter int unsigned EV_DEPTH      = FIFO_DEPTH
) (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic       i_sclk,
    input  wire logic       i_port_select_n,
    input  wire logic       i_shift_in,
    input  wire logic       i_cal_busy,
    input  wire logic [7:0] i_cal_state,
    input  wire logic [7:0] i_sync_capture_pos,
    output logic            o_shift_out,
    output logic            o_shift_out_oe_n,
    output logic            o_event_lost
);
    srap_core_type  core_r;
    srap_core_type  core_nxt;
    srap_event_type link_ev;
    srap_event_type ev;
    logic           link_ev_valid;
    logic           link_ev_ready;
    logic           ev_valid;
    logic           ev_ready;
    logic           link_lost;
    logic           up;
    logic           hold;
    srap_hit_type   wh;

    // the address wraps within fifteen bits; the hold bit wins over the direction
    function automatic logic [ADDR_W-1:0] addr_step(
        input logic [ADDR_W-1:0] a,
        input logic              dir_up,
        input logic              hold_addr
    );
        if (hold_addr) begin
            return a;
        end
        return dir_up ? a + 15'h0001 : a - 15'h0001;
    endfunction : addr_step

    // unlisted addresses read as zero; status bytes come live from the inputs
    function automatic logic [7:0] byte_read(
        input srap_core_type     c,
        input logic [ADDR_W-1:0] a
    );
        srap_hit_type h;
        logic [7:0]   v;
        h = reg_find(a);
        v = 8'h00;
        if (h.hit) begin
            unique case (REG_KIND[h.idx])
                RK_RW: begin
                    v = c.regs[h.idx];
                end
                RK_ID: begin
                    if (a == OFS_PART_CAT) begin
                        v = PART_CATEGORY;
                    end else if (a == OFS_PART_ID) begin
                        v = PART_IDENT;
                    end else if (a == OFS_MAKER_LO) begin
                        v = MAKER_IDENT[7:0];
                    end else begin
                        v = MAKER_IDENT[15:8];
                    end
                end
                RK_STAT: begin
                    v = (a == OFS_SYNC_POS) ? i_sync_capture_pos : i_cal_state;
                end
            endcase
        end
        return v;
    endfunction : byte_read

    // a write with either copy of the direction bit set sets both copies; both copies clear only when both are written as zero
    function automatic logic dir_fold(input logic [7:0] d);
        return d[DIR_HI_POS] | d[DIR_LO_POS];
    endfunction : dir_fold

    // the link reset stays high through the core reset and one edge beyond
    function automatic srap_core_type core_reset();
        srap_core_type c;
        c          = '0;
        c.link_rst = 1'b1;
        for (int i = 0; i < NREG; i++) begin
            c.regs[i] = REG_RST[i];
        end
        return c;
    endfunction : core_reset

    // the frame logic runs on the serial clock alone
    srap_link u_link (
        .i_sclk           (i_sclk),
        .i_port_select_n  (i_port_select_n),
        .i_link_rst       (core_r.link_rst),
        .i_shift_in       (i_shift_in),
        .i_rd_byte        (core_r.rd_byte),
        .i_ev_ready       (link_ev_ready),
        .o_ev_valid       (link_ev_valid),
        .o_ev             (link_ev),
        .o_lost           (link_lost),
        .o_shift_out      (o_shift_out),
        .o_shift_out_oe_n (o_shift_out_oe_n)
    );

    // events cross into the core clock through the fifo's gray pointers
    srap_fifo #(
        .WIDTH ($bits(srap_event_type)),
        .DEPTH (EV_DEPTH)
    ) u_fifo (
        .i_wr_clk   (i_sclk),
        .i_wr_rst   (core_r.link_rst),
        .i_wr_valid (link_ev_valid),
        .o_wr_ready (link_ev_ready),
        .i_wr_data  (link_ev),
        .i_rd_clk   (i_clk),
        .i_rd_srst  (i_srst),
        .o_rd_valid (ev_valid),
        .i_rd_ready (ev_ready),
        .o_rd_data  (ev)
    );

    // events wait in the fifo while calibration runs
    assign ev_ready = ~i_cal_busy;

    // one event per core clock; the step after a data byte uses the direction
    // and hold bits as they stood before that byte was written
    always_comb begin
        core_nxt           = core_r;
        up                 = core_r.regs[IDX_IF_CFG][DIR_HI_POS];
        hold               = core_r.regs[IDX_USER_CFG][HOLD_POS];
        wh                 = reg_find(core_r.cur);
        core_nxt.link_rst  = 1'b0;
        // two flip-flops carry the sticky lost flag over from the serial clock
        core_nxt.lost_sync = {core_r.lost_sync[0], link_lost};
        core_nxt.lost      = core_r.lost_sync[1];
        if (ev_valid && ev_ready) begin
            unique case (ev.kind)
                EV_ADDR: begin
                    core_nxt.cur = ev.payload;
                end
                EV_WDATA: begin
                    if (wh.hit && REG_KIND[wh.idx] == RK_RW) begin
                        core_nxt.regs[wh.idx] = ev.payload[7:0];
                        if (wh.idx == 6'(IDX_IF_CFG)) begin
                            core_nxt.regs[wh.idx][DIR_HI_POS] =
                                dir_fold(ev.payload[7:0]);
                            core_nxt.regs[wh.idx][DIR_LO_POS] =
                                dir_fold(ev.payload[7:0]);
                        end
                    end
                    core_nxt.cur = addr_step(core_r.cur, up, hold);
                end
                EV_RDONE: begin
                    core_nxt.cur = addr_step(core_r.cur, up, hold);
                end
            endcase
        end
        // refreshed every core clock so status bytes are current when shifted
        core_nxt.rd_byte = byte_read(core_r, core_r.cur);
        if (i_srst) begin
            core_nxt = core_reset();
        end
    end

    always_ff @(posedge i_clk) begin
        core_r <= core_nxt;
    end

    assign o_event_lost = core_r.lost;

endmodule : srap_top

// ### common/srap_pkg.sv
// constants, types and register table of the serial register access port
// Function
// - select low frames access; high ignores port
// - sample shift_in on rising clock edge
// - static state, no timeout, any rate
// - each access is a 24-bit frame
// - all fields shifted msb first
// - wide registers stored little-endian
// - shift_out undriven except read data bits
// - first bit one reads, zero writes
// - next fifteen bits give register address
// - write frame stores last eight bits
// - read frame drives register on shift_out
// - further bytes stream while select low
// - streaming steps address up or down
// - direction bits five and two, register zero
// - address-hold bit stops address stepping
package srap_pkg;

    localparam int unsigned ADDR_W     = 15;
    localparam int unsigned NREG       = 44;
    localparam int unsigned FIFO_DEPTH = 32;

    // rising-edge counts within a frame
    localparam logic [4:0] CNT_RW_BIT   = 5'h00;
    localparam logic [4:0] CNT_ADDR_END = 5'h0f;
    localparam logic [4:0] CNT_DATA_BEG = 5'h10;
    localparam logic [4:0] CNT_DATA_END = 5'h17;
    localparam logic [4:0] CNT_FRAME    = 5'h18;
    localparam logic [4:0] CNT_STREAM   = 5'h11;

    localparam int unsigned DIR_HI_POS   = 5;
    localparam int unsigned DIR_LO_POS   = 2;
    localparam int unsigned HOLD_POS     = 0;
    localparam int unsigned IDX_IF_CFG   = 0;
    localparam int unsigned IDX_USER_CFG = 6;

    localparam logic [14:0] OFS_PART_CAT = 15'h0003;
    localparam logic [14:0] OFS_PART_ID  = 15'h0004;
    localparam logic [14:0] OFS_MAKER_LO = 15'h000c;
    localparam logic [14:0] OFS_SYNC_POS = 15'h002c;

    typedef enum logic [2:0] {
        RK_RW   = 3'b001,
        RK_ID   = 3'b010,
        RK_STAT = 3'b100
    } srap_reg_kind_type;

    typedef enum logic [2:0] {
        EV_ADDR  = 3'b001,
        EV_WDATA = 3'b010,
        EV_RDONE = 3'b100
    } srap_ev_kind_type;

    // one entry per byte address; 16-bit registers take two entries
    localparam logic [14:0] REG_ADDR [NREG] = '{
        15'h000, 15'h002, 15'h003, 15'h004, 15'h00c, 15'h00d, 15'h010, 15'h029,
        15'h02a, 15'h02b, 15'h02c, 15'h030, 15'h031, 15'h032, 15'h033, 15'h038,
        15'h03b, 15'h048, 15'h060, 15'h061, 15'h062, 15'h064, 15'h068, 15'h06a,
        15'h06b, 15'h06c, 15'h06e, 15'h070, 15'h071, 15'h07a, 15'h07b, 15'h07c,
        15'h07e, 15'h07f, 15'h09d, 15'h160, 15'h200, 15'h201, 15'h202, 15'h203,
        15'h204, 15'h205, 15'h206, 15'h207};

    localparam logic [7:0] REG_RST [NREG] = '{
        8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h11, 8'h00, 8'h00, 8'ha0, 8'h00, 8'ha0, 8'h00,
        8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h61, 8'h00,
        8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h1f, 8'h01,
        8'h03, 8'h00, 8'h00, 8'h00};

    localparam srap_reg_kind_type REG_KIND [NREG] = '{
        RK_RW, RK_RW, RK_ID, RK_ID, RK_ID, RK_ID, RK_RW, RK_RW,
        RK_RW, RK_RW, RK_STAT, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW,
        RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_STAT,
        RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW,
        RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW, RK_RW,
        RK_RW, RK_RW, RK_RW, RK_RW};

    typedef struct packed {
        srap_ev_kind_type    kind;
        logic [ADDR_W-1:0]   payload;
    } srap_event_type;

    typedef struct packed {
        logic [4:0]          cnt;
        logic                rd;
        logic [ADDR_W-1:0]   sh;
    } srap_link_type;

    typedef struct packed {
        logic                bit_o;
        logic                oe_n;
        logic [6:0]          pend;
    } srap_out_type;

    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic [ADDR_W-1:0]    cur;
        logic [7:0]           rd_byte;
        logic                 link_rst;
        logic [1:0]           lost_sync;
        logic                 lost;
    } srap_core_type;

    typedef struct packed {
        logic       hit;
        logic [5:0] idx;
    } srap_hit_type;

    localparam srap_link_type LINK_RST = '{cnt: CNT_RW_BIT, rd: 1'b0, sh: '0};
    localparam srap_out_type  OUT_RST  = '{bit_o: 1'b0, oe_n: 1'b1, pend: '0};

    function automatic srap_hit_type reg_find(input logic [ADDR_W-1:0] a);
        srap_hit_type h;
        h = '0;
        for (int i = 0; i < NREG; i++) begin
            if (REG_ADDR[i] == a) begin
                h.hit = 1'b1;
                h.idx = 6'(i);
            end
        end
        return h;
    endfunction : reg_find

endpackage : srap_pkg

// ### testbench/srap_host_model.sv
// serial host model: drives frames, clock only inside frames
`timescale 1ns/1ps
module srap_host_model (
    output logic      o_sclk,
    output logic      o_port_select_n,
    output logic      o_shift_in,
    input  wire logic i_shift_out,
    input  wire logic i_shift_out_oe_n
);
    localparam realtime HALF = 62.5;
    logic sdo_wire;

    // pin floats while the device does not drive it
    assign sdo_wire = i_shift_out_oe_n ? 1'bz : i_shift_out;

    initial begin
        o_sclk          = 1'b0;
        o_shift_in      = 1'b0;
        // a clean rising select edge clears the frame logic at start-up
        #1 o_port_select_n = 1'b1;
    end

    // nb rising edges; fewer than 24 cuts the frame short
    task automatic xfer(input logic rd, input logic [14:0] addr, input int nb,
                        input logic [7:0] wd [8], output logic [7:0] rdat [8]);
        logic [15:0] hdr;
        hdr = {rd, addr};
        o_port_select_n = 1'b0;
        #(HALF);
        for (int i = 0; i < nb; i++) begin
            if (i < 16) begin
                o_shift_in = hdr[15-i];
            end else if (rd) begin
                o_shift_in = ~o_shift_in;
            end else begin
                o_shift_in = wd[(i-16)/8][7-(i-16)%8];
            end
            #(HALF) o_sclk = 1'b1;
            if (i >= 16) begin
                rdat[(i-16)/8][7-(i-16)%8] = sdo_wire;
            end
            #(HALF) o_sclk = 1'b0;
        end
        #(HALF);
        o_port_select_n = 1'b1;
        // released line shows no stale level
        o_shift_in = ~o_shift_in;
        #(HALF);
    endtask : xfer
endmodule : srap_host_model

// ### testbench/srap_checker.sv
// concurrent checks on the serial register access port pins
`timescale 1ns/1ps
module srap_checker (
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic       i_sclk,
    input wire logic       i_port_select_n,
    input wire logic       i_shift_in,
    input wire logic       i_cal_busy,
    input wire logic [7:0] i_cal_state,
    input wire logic [7:0] i_sync_capture_pos,
    input wire logic       o_shift_out,
    input wire logic       o_shift_out_oe_n,
    input wire logic       o_event_lost
);
    logic [6:0] cnt_r;
    logic       rd_r;

    // frame edge count; saturates so long streams stay in the data phase
    always_ff @(posedge i_sclk or posedge i_port_select_n) begin
        if (i_port_select_n) begin
            cnt_r <= 7'h00;
            rd_r  <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 7'h7f) ? cnt_r : cnt_r + 7'h01;
            rd_r  <= (cnt_r == 7'h00) ? i_shift_in : rd_r;
        end
    end

    hdr_quiet_a: assert property (@(posedge i_sclk) disable iff (i_port_select_n || i_srst)
        cnt_r < 7'd16 |-> o_shift_out_oe_n) else $error("shift_out driven in header");
    write_quiet_a: assert property (@(posedge i_sclk) disable iff (i_port_select_n || i_srst)
        !rd_r && cnt_r > 7'd0 |-> o_shift_out_oe_n) else $error("shift_out driven in write");
    read_drive_a: assert property (@(posedge i_sclk) disable iff (i_port_select_n || i_srst)
        rd_r && cnt_r >= 7'd16 |-> !o_shift_out_oe_n) else $error("read data not driven");
    idle_release_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_port_select_n && $past(i_port_select_n) |-> o_shift_out_oe_n)
        else $error("shift_out driven while deselected");
    lost_sticky_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_event_lost |=> o_event_lost) else $error("event lost flag cleared");
    reset_state_a: assert property (@(posedge i_clk)
        i_srst && $past(i_srst) |-> !o_event_lost && o_shift_out_oe_n)
        else $error("outputs not at reset level");
    out_on_fall_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $changed(o_shift_out) && !o_shift_out_oe_n |-> !i_sclk)
        else $error("shift_out moved while sclk high");
    enable_on_fall_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(o_shift_out_oe_n) |-> !i_sclk && !i_port_select_n)
        else $error("drive started off a falling edge");

    cover property (@(posedge i_sclk) rd_r && cnt_r == 7'd24);
    cover property (@(posedge i_sclk) !rd_r && cnt_r == 7'd39);
    cover property (@(posedge i_clk) i_cal_busy && $rose(o_event_lost));
endmodule : srap_checker

bind srap_top srap_checker u_chk (
    .i_clk              (i_clk),
    .i_srst             (i_srst),
    .i_sclk             (i_sclk),
    .i_port_select_n    (i_port_select_n),
    .i_shift_in         (i_shift_in),
    .i_cal_busy         (i_cal_busy),
    .i_cal_state        (i_cal_state),
    .i_sync_capture_pos (i_sync_capture_pos),
    .o_shift_out        (o_shift_out),
    .o_shift_out_oe_n   (o_shift_out_oe_n),
    .o_event_lost       (o_event_lost)
);

// ### testbench/tb_serial_register_access_port.sv
// self-checking bench: host model frames against the port
`timescale 1ns/1ps
module tb_serial_register_access_port
    import srap_pkg::*;
;

    localparam logic [7:0]  PCAT = 8'h3c;    // arbitrary value
    localparam logic [7:0]  PID  = 8'h47;    // arbitrary value
    localparam logic [15:0] MID  = 16'h2b6e; // arbitrary value

    logic        i_clk;
    logic        i_srst;
    logic        i_cal_busy;
    logic [7:0]  cal_state;
    logic [7:0]  sync_pos;
    logic        sclk;
    logic        sel_n;
    logic        shift_in;
    logic        shift_out;
    logic        sdo_oe_n;
    logic        ev_lost;
    int          fail_count;
    int          n_compared;
    int          idx;
    logic [31:0] rng;
    logic [7:0]  exp_r [NREG];
    logic [7:0]  wd [8];
    logic [7:0]  rd_b [8];

    srap_top #(.PART_CATEGORY(PCAT), .PART_IDENT(PID), .MAKER_IDENT(MID),
               .EV_DEPTH(FIFO_DEPTH)) DUT (
        .i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_port_select_n(sel_n),
        .i_shift_in(shift_in), .i_cal_busy(i_cal_busy), .i_cal_state(cal_state),
        .i_sync_capture_pos(sync_pos), .o_shift_out(shift_out),
        .o_shift_out_oe_n(sdo_oe_n), .o_event_lost(ev_lost));

    srap_host_model host (.o_sclk(sclk), .o_port_select_n(sel_n), .o_shift_in(shift_in),
        .i_shift_out(shift_out), .i_shift_out_oe_n(sdo_oe_n));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    // both copies of the streaming direction bit take the or of the written copies
    function automatic logic [7:0] cfg_fold(input logic [7:0] d);
        logic f;
        f = d[DIR_HI_POS] | d[DIR_LO_POS];
        d[DIR_HI_POS] = f;
        d[DIR_LO_POS] = f;
        return d;
    endfunction : cfg_fold

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic do_reset();
        @(posedge i_clk);
        #1 i_srst = 1'b1;
        repeat (8) @(posedge i_clk);
        #1 i_srst = 1'b0;
        for (int i = 0; i < NREG; i++) exp_r[i] = REG_RST[i];
        exp_r[2]  = PCAT;
        exp_r[3]  = PID;
        exp_r[4]  = MID[7:0];
        exp_r[5]  = MID[15:8];
        exp_r[10] = sync_pos;
        exp_r[23] = cal_state;
        repeat (2) @(posedge i_clk);
    endtask : do_reset

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        wd[0] = d;
        host.xfer(1'b0, a, 24, wd, rd_b);
    endtask : wr

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 24, wd, rd_b);
        check("read byte", rd_b[0], e);
    endtask : rd_chk

    initial begin
        #380000;
        fail_count++;
        give_verdict();
    end

    initial begin
        i_srst     = 1'b1;
        i_cal_busy = 1'b0;
        fail_count = 0;
        n_compared = 0;
        wd         = '{default: 8'h00};
        rng        = xs(32'd82177);
        cal_state  = rng[7:0];
        sync_pos   = rng[15:8];
        do_reset();
        for (int i = 0; i < NREG; i++) rd_chk(REG_ADDR[i], exp_r[i]);
        // 0x000 and 0x010 steer streaming, covered separately
        for (int k = 0; k < 12; k++) begin
            rng = xs(rng);
            idx = 7 + int'(rng[15:8]) % (NREG - 7);
            wr(REG_ADDR[idx], rng[7:0]);
            if (REG_KIND[idx] == RK_RW) exp_r[idx] = rng[7:0];
            rd_chk(REG_ADDR[idx], exp_r[idx]);
        end
        wr(15'h0001, 8'ha5);
        rd_chk(15'h0001, 8'h00);
        wd[0] = ~exp_r[7];
        host.xfer(1'b0, 15'h0029, 23, wd, rd_b);
        rd_chk(15'h0029, exp_r[7]);
        for (int k = 0; k < 3; k++) begin
            rng = xs(rng);
            wd[k] = rng[7:0];
            exp_r[7+k] = rng[7:0];
        end
        host.xfer(1'b0, 15'h0029, 40, wd, rd_b);
        host.xfer(1'b1, 15'h0029, 40, wd, rd_b);
        for (int k = 0; k < 3; k++) check("ascending", rd_b[k], exp_r[7+k]);
        wr(15'h0000, 8'h00);
        rd_chk(15'h0000, cfg_fold(8'h00));
        host.xfer(1'b1, 15'h002b, 40, wd, rd_b);
        for (int k = 0; k < 3; k++) check("descending", rd_b[k], exp_r[9-k]);
        wr(15'h0000, 8'h04);
        rd_chk(15'h0000, cfg_fold(8'h04));
        wr(15'h0010, 8'h01);
        wd[0] = 8'h5c;
        wd[1] = 8'hc3;
        host.xfer(1'b0, 15'h0048, 32, wd, rd_b);
        rd_chk(15'h0048, 8'hc3);
        rd_chk(15'h0060, exp_r[18]);
        wr(15'h0010, 8'h00);
        check("lost idle", {7'h00, ev_lost}, 8'h00);
        @(posedge i_clk);
        #1 i_cal_busy = 1'b1;
        for (int k = 0; k < 20; k++) wr(15'h0029, 8'(k));
        check("lost full", {7'h00, ev_lost}, 8'h01);
        @(posedge i_clk);
        #1 i_cal_busy = 1'b0;
        repeat (100) @(posedge i_clk);
        do_reset();
        check("lost reset", {7'h00, ev_lost}, 8'h00);
        rd_chk(15'h0000, 8'h30);
        rd_chk(15'h0029, exp_r[7]);
        give_verdict();
    end
endmodule : tb_serial_register_access_port
